// ==== quad_out_defs.svh ====
// Constants of the quadrature output supervisor
`ifndef QUAD_OUT_DEFS_SVH
`define QUAD_OUT_DEFS_SVH
`define QO_CLK_HZ          50000000
`define QO_PULSES_PER_REV  4096
`define QO_POS_WIDTH       14
`define QO_OVLT_HOLD_MS    200
`define QO_OVLT_HOLD_CYC   ((`QO_CLK_HZ / 1000) * `QO_OVLT_HOLD_MS)
`define QO_ADDR_MIN        7'h01
`define QO_ADDR_MAX        7'h63
`define QO_BAUD_MIN_BPS    9600
`define QO_BAUD_MAX_BPS    12000000
`define QO_BAUD_CNT_W      24
`endif

// ==== quad_out_pkg.sv ====
// Types of the quadrature output supervisor
package quad_out_pkg;
  typedef enum logic [1:0] {
    ST_WAIT_ADDR,
    ST_RUN,
    ST_ABSENT,
    ST_LOCKED
  } sup_state_t;

  typedef struct packed {
    logic chan_a;
    logic chan_b;
  } quad_pair_t;

  typedef struct packed {
    logic [3:0] tens;
    logic [3:0] units;
  } addr_switch_t;
endpackage

// ==== sync2.sv ====
// Two flip-flop synchroniser for one level
`timescale 1ns/10ps
module sync2 (
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_q;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // sync2

// ==== quadrature_output_supervisor.sv ====
// Quadrature output generation, start-up gating and protection shutdown
`timescale 1ns/10ps
`include "quad_out_defs.svh"

module quadrature_output_supervisor #(
  parameter int unsigned OVLT_HOLD_CYC = `QO_OVLT_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_n_i,
  // Shaft position, same clock domain
  input  wire logic [`QO_POS_WIDTH-1:0]  shaft_pos_i,
  // Comparator, switch and bus receive pins
  input  wire logic                      feed_in_high_i,
  input  wire logic                      supply_over_i,
  input  wire quad_out_pkg::addr_switch_t addr_sw_i,
  input  wire logic                      bus_rx_i,
  // Incremental outputs
  output quad_out_pkg::quad_pair_t       quad_o,
  output logic                           quad_oe_n_o,
  // Bus side
  output logic                           bus_tx_o,
  output logic                           bus_tx_oe_n_o,
  output logic                           bus_enable_o,
  output logic [6:0]                     station_addr_o,
  output logic [6:0]                     dest_addr_o,
  output logic [`QO_BAUD_CNT_W-1:0]      bit_time_o,
  output logic                           bit_time_valid_o,
  // Status
  output logic                           running_o,
  output logic                           locked_o
);
  // ==========================================================
  // Pin synchronisation
  logic feed_s;
  logic over_s;
  logic rx_s;
  logic [7:0] sw_s;

  sync2 u_sync_feed (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
                     .async_i(feed_in_high_i), .sync_o(feed_s));
  sync2 u_sync_over (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
                     .async_i(supply_over_i), .sync_o(over_s));
  sync2 u_sync_rx   (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
                     .async_i(bus_rx_i), .sync_o(rx_s));

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sw
      sync2 u_sync_sw (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
                       .async_i(addr_sw_i[gi]), .sync_o(sw_s[gi]));
    end
  endgenerate

  // ==========================================================
  // Address decode
  logic [6:0] addr_val;
  logic       addr_ok;

  always_comb begin
    addr_val = 7'h00;
    addr_ok  = 1'b0;
    if (sw_s[7:4] <= 4'h9 && sw_s[3:0] <= 4'h9) begin
      // Widened before the product so tens times ten cannot wrap at 4 bits
      addr_val = ({3'h0, sw_s[7:4]} * 7'h0a) + {3'h0, sw_s[3:0]};
      addr_ok  = (addr_val >= `QO_ADDR_MIN) && (addr_val <= `QO_ADDR_MAX);
    end
  end

  // ==========================================================
  // Overvoltage timer
  logic [31:0] over_cnt_q;
  logic        over_trip;

  assign over_trip = over_s && (over_cnt_q >= OVLT_HOLD_CYC);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      over_cnt_q <= 32'h0;
    end else if (!over_s) begin
      over_cnt_q <= 32'h0;
    end else if (over_cnt_q < OVLT_HOLD_CYC) begin
      over_cnt_q <= over_cnt_q + 32'h1;
    end
  end

  // ==========================================================
  // Supervisor state
  quad_out_pkg::sup_state_t state_q;
  logic [6:0] addr_q;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= quad_out_pkg::ST_WAIT_ADDR;
    end else begin
      case (state_q)
        quad_out_pkg::ST_WAIT_ADDR: begin
          if (over_trip)
            state_q <= quad_out_pkg::ST_LOCKED;
          else if (feed_s)
            state_q <= quad_out_pkg::ST_ABSENT;
          else if (addr_ok)
            state_q <= quad_out_pkg::ST_RUN;
        end
        quad_out_pkg::ST_RUN: begin
          if (over_trip)
            state_q <= quad_out_pkg::ST_LOCKED;
          else if (feed_s)
            state_q <= quad_out_pkg::ST_ABSENT;
        end
        // Absent until the next power-on reset or an overvoltage trip to ST_LOCKED
        quad_out_pkg::ST_ABSENT: begin
          if (over_trip)
            state_q <= quad_out_pkg::ST_LOCKED;
        end
        quad_out_pkg::ST_LOCKED: state_q <= quad_out_pkg::ST_LOCKED;
        default: state_q <= quad_out_pkg::ST_LOCKED;
      endcase
    end
  end

  // Address frozen at start-up; switches moved later are ignored
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_q <= 7'h00;
    end else if (state_q == quad_out_pkg::ST_WAIT_ADDR && addr_ok) begin
      addr_q <= addr_val;
    end
  end

  logic run;
  assign run = (state_q == quad_out_pkg::ST_RUN);

  // ==========================================================
  // Quadrature generation
  logic [`QO_POS_WIDTH-1:0] pos_q;
  logic [1:0]               phase_q;
  logic                     init_q;
  logic                     step_up_q;

  // 4096 pulses, four steps each, over a 14-bit turn
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pos_q     <= '0;
      phase_q   <= 2'h0;
      init_q    <= 1'b0;
      step_up_q <= 1'b1;
    end else if (!init_q) begin
      pos_q   <= shaft_pos_i;
      phase_q <= shaft_pos_i[1:0];
      init_q  <= 1'b1;
    end else if (pos_q != shaft_pos_i) begin
      // one step per clock toward target
      if (14'(shaft_pos_i - pos_q) < 14'h2000) begin
        pos_q     <= pos_q + 14'h1;
        phase_q   <= phase_q + 2'h1;
        step_up_q <= 1'b1;
      end else begin
        pos_q     <= pos_q - 14'h1;
        phase_q   <= phase_q - 2'h1;
        step_up_q <= 1'b0;
      end
    end
  end

  // gray phase gives 90 degree offset
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quad_o <= '0;
    end else begin
      // Upward (A,B) runs 00,10,11,01 so A leads B
      quad_o.chan_a <= run & (phase_q[1] ^ phase_q[0]);
      quad_o.chan_b <= run & phase_q[1];
    end
  end

  assign quad_oe_n_o   = ~run;
  assign bus_tx_oe_n_o = ~run;
  assign bus_tx_o      = 1'b1;
  assign bus_enable_o  = run;
  assign running_o     = run;
  assign locked_o      = (state_q == quad_out_pkg::ST_LOCKED);
  assign station_addr_o = addr_q;
  assign dest_addr_o   = addr_q;

  // ==========================================================
  // Bit rate detection: shortest low pulse seen is one bit time
  logic                      rx_d1_q;
  logic [`QO_BAUD_CNT_W-1:0] low_cnt_q;
  logic [`QO_BAUD_CNT_W-1:0] best_q;
  logic                      best_ok_q;
  localparam logic [`QO_BAUD_CNT_W-1:0] BIT_MAX =
    `QO_BAUD_CNT_W'(`QO_CLK_HZ / `QO_BAUD_MIN_BPS);
  localparam logic [`QO_BAUD_CNT_W-1:0] BIT_MIN =
    `QO_BAUD_CNT_W'(`QO_CLK_HZ / `QO_BAUD_MAX_BPS);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_d1_q   <= 1'b1;
      low_cnt_q <= '0;
      best_q    <= '0;
      best_ok_q <= 1'b0;
    end else begin
      rx_d1_q <= rx_s;
      if (!rx_s) begin
        if (low_cnt_q <= BIT_MAX)
          low_cnt_q <= low_cnt_q + `QO_BAUD_CNT_W'(1);
      end else begin
        low_cnt_q <= '0;
        if (!rx_d1_q && low_cnt_q >= BIT_MIN && low_cnt_q <= BIT_MAX &&
            (!best_ok_q || low_cnt_q < best_q)) begin
          best_q    <= low_cnt_q;
          best_ok_q <= 1'b1;
        end
      end
    end
  end

  assign bit_time_o       = best_q;
  assign bit_time_valid_o = best_ok_q & run;

  // ==========================================================
  // Checks
  // no start without address
  chk_start_needs_addr: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ($past(state_q) == quad_out_pkg::ST_WAIT_ADDR && run) |-> $past(addr_ok))
    else $error("started without valid address");
  chk_absent_quiet: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (state_q == quad_out_pkg::ST_ABSENT) |-> (quad_oe_n_o && bus_tx_oe_n_o && !bus_enable_o))
    else $error("absent device still drives");
  chk_feed_shutdown: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (run && feed_s && !over_trip) |=> (state_q == quad_out_pkg::ST_ABSENT))
    else $error("feed-in did not shut down");
  chk_lock_sticky: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    locked_o |=> locked_o)
    else $error("permanent lock released");
  chk_lock_cause: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(locked_o) |-> $past(over_cnt_q) >= OVLT_HOLD_CYC)
    else $error("lock before hold time");
  chk_dest_addr: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    dest_addr_o == station_addr_o)
    else $error("destination address differs");
  chk_addr_range: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    run |-> (addr_q >= `QO_ADDR_MIN && addr_q <= `QO_ADDR_MAX))
    else $error("running address out of range");
  // one channel per step, once the outputs left their idle value
  chk_one_edge: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (run && $past(run) && $past(run, 2)) |->
      !($changed(quad_o.chan_a) && $changed(quad_o.chan_b)))
    else $error("both channels changed at once");
  // A rises with B low on an upward step only
  chk_lead_dir: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (run && $past(run) && $past(run, 2) && $rose(quad_o.chan_a)) |->
      (quad_o.chan_b != $past(step_up_q)))
    else $error("channel A edge with wrong B level");
  chk_bit_band: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    best_ok_q |-> (best_q >= BIT_MIN && best_q <= BIT_MAX))
    else $error("bit time outside band");
  // outputs held low from the cycle after they are released
  chk_quad_idle: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !$past(run) |-> (quad_o == '0))
    else $error("incremental outputs active while released");
  // waiting device stays off the bus
  chk_wait_quiet: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (state_q == quad_out_pkg::ST_WAIT_ADDR) |-> (quad_oe_n_o && bus_tx_oe_n_o && !bus_enable_o))
    else $error("waiting device drives");
  // tracker moves at most one count per clock
  chk_pos_step: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $past(init_q) |-> (14'(pos_q - $past(pos_q)) inside {14'h0000, 14'h0001, 14'h3fff}))
    else $error("position tracker jumped");
  // four steps per pulse, phase locked to position
  chk_phase_pos: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    init_q |-> (phase_q == pos_q[1:0]))
    else $error("phase lost track of position");

  cov_run: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $rose(run));
  cov_absent: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(state_q == quad_out_pkg::ST_ABSENT));
  cov_lock: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $rose(locked_o));
  cov_rate: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $rose(best_ok_q));
  cov_reverse: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $fell(step_up_q));
endmodule // quadrature_output_supervisor

// ==== quad_counter_model.sv ====
// Drive-side model that counts quadrature steps on the incremental outputs
`timescale 1ns/10ps
module quad_counter_model (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  // Counter clear, synchronous
  input  wire logic                     clr_i,
  // Incremental lines from the encoder
  input  wire quad_out_pkg::quad_pair_t quad_i,
  input  wire logic                     quad_oe_n_i,
  // Counter state
  output int                            count_o,
  output int                            a_rise_o,
  output int                            bad_step_o
);
  // ==========================================================
  // Decoder
  logic [1:0] prev_q;
  logic [1:0] phase;
  // A leads B upward: (A,B) 00,10,11,01 decodes to 0,1,2,3
  assign phase = {quad_i.chan_b, quad_i.chan_a ^ quad_i.chan_b};

  // quarter-phase decode, single change per step
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o    <= 0;
      a_rise_o   <= 0;
      bad_step_o <= 0;
    end else if (clr_i) begin
      count_o    <= 0;
      a_rise_o   <= 0;
      bad_step_o <= 0;
    // Released lines are not counted, like an open receiver input
    end else if (!quad_oe_n_i && phase != prev_q) begin
      case (2'(phase - prev_q))
        2'h1:    count_o <= count_o + 1;
        2'h3:    count_o <= count_o - 1;
        default: bad_step_o <= bad_step_o + 1;
      endcase
      // Previous A level is the xor of the stored phase bits
      if (quad_i.chan_a && !(prev_q[1] ^ prev_q[0])) begin
        a_rise_o <= a_rise_o + 1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= 2'h0;
    end else begin
      prev_q <= phase;
    end
  end
endmodule // quad_counter_model

// ==== quadrature_output_supervisor_test.sv ====
// Self-checking testbench of the quadrature output supervisor
`timescale 1ns/10ps
module quadrature_output_supervisor_test;
  localparam int HOLD = 20;
  localparam int K_RUN = 0, K_STA = 1, K_DST = 2, K_CNT = 3, K_RISE = 4, K_BAD = 5;
  localparam int K_OE = 6, K_EN = 7, K_LCK = 8, K_BIT = 9, K_TXOE = 10, K_TX = 11;
  // ==========================================================
  // Signals
  logic                       ref_clk_i = 1'b0;
  logic                       reset_n_i = 1'b0;
  logic [13:0]                shaft_pos;
  logic                       feed_in_high, supply_over, bus_rx, clr;
  quad_out_pkg::addr_switch_t addr_sw;
  quad_out_pkg::quad_pair_t   quad;
  logic                       quad_oe_n, bus_tx, bus_tx_oe_n, bus_enable, running, locked;
  logic [6:0]                 station_addr, dest_addr;
  logic [23:0]                bit_time;
  logic                       bit_time_valid;
  int                         count, a_rise, bad_step, error_cnt = 0, n_compared = 0;
  logic [39:0]                exp_q[$];
  event                       sample_ev;

  always #10 ref_clk_i = ~ref_clk_i;

  quadrature_output_supervisor #(.OVLT_HOLD_CYC(HOLD)) DUT (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .shaft_pos_i(shaft_pos),
    .feed_in_high_i(feed_in_high), .supply_over_i(supply_over), .addr_sw_i(addr_sw),
    .bus_rx_i(bus_rx), .quad_o(quad), .quad_oe_n_o(quad_oe_n), .bus_tx_o(bus_tx),
    .bus_tx_oe_n_o(bus_tx_oe_n), .bus_enable_o(bus_enable), .station_addr_o(station_addr),
    .dest_addr_o(dest_addr), .bit_time_o(bit_time), .bit_time_valid_o(bit_time_valid),
    .running_o(running), .locked_o(locked));

  quad_counter_model drive (
    .clk_i(ref_clk_i), .rst_n_i(reset_n_i), .clr_i(clr), .quad_i(quad),
    .quad_oe_n_i(quad_oe_n), .count_o(count), .a_rise_o(a_rise), .bad_step_o(bad_step));

  // ==========================================================
  // Notes, monitor and verdict
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic compare_val(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic note(input int k, input logic [31:0] v);
    exp_q.push_back({k[7:0], v});
    -> sample_ev;
    #1;
  endtask

  always @(sample_ev) begin
    logic [39:0] e;
    logic [31:0] obs;
    e = exp_q.pop_front();
    case (int'(e[39:32]))
      K_RUN:   obs = 32'(running);
      K_STA:   obs = 32'(station_addr);
      K_DST:   obs = 32'(dest_addr);
      K_CNT:   obs = 32'(count);
      K_RISE:  obs = 32'(a_rise);
      K_BAD:   obs = 32'(bad_step);
      K_OE:    obs = 32'(quad_oe_n);
      K_EN:    obs = 32'(bus_enable);
      K_LCK:   obs = 32'(locked);
      K_BIT:   obs = {bit_time_valid, 7'h00, bit_time};
      K_TX:    obs = 32'(bus_tx);
      default: obs = 32'(bus_tx_oe_n);
    endcase
    compare_val(obs, e[31:0]);
  end

  initial begin
    repeat (60000) @(posedge ref_clk_i);
    error_cnt++;
    report_and_stop();
  end

  // ==========================================================
  // Stimulus, at the falling edge, or 1 ns later for each note() that comes before it
  task automatic reset_dut();
    reset_n_i = 1'b0;
    repeat (20) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  task automatic turn(input int steps, input int dir);
    clr = 1'b1;
    wait_cycles(1);
    clr = 1'b0;
    for (int i = 0; i < steps; i++) begin
      @(negedge ref_clk_i);
      shaft_pos = shaft_pos + 14'(dir);
    end
    wait_cycles(6);
  endtask

  task automatic low_pulse(input int w);
    bus_rx = 1'b0;
    wait_cycles(w);
    bus_rx = 1'b1;
    wait_cycles(100);
  endtask

  initial begin
    logic [3:0] t, u;
    logic [7:0] bad_sw[4] = '{8'h00, 8'ha5, 8'h3c, 8'hf1};
    void'($urandom(63581));
    {shaft_pos, feed_in_high, supply_over, clr} = '0;
    bus_rx  = 1'b1;
    addr_sw = 8'h00;
    reset_dut();
    foreach (bad_sw[i]) begin
      addr_sw = bad_sw[i];
      wait_cycles(8);
      note(K_RUN, 0);
      note(K_EN, 0);
      note(K_OE, 1);
    end
    t = 4'($urandom % 10);
    u = 4'($urandom % 10);
    if (t == 4'h0 && u == 4'h0) u = 4'h1;
    addr_sw = '{tens: t, units: u};
    for (int i = 0; i < 20 && running !== 1'b1; i++) wait_cycles(1);
    note(K_RUN, 1);
    note(K_STA, t * 10 + u);
    note(K_DST, t * 10 + u);
    note(K_EN, 1);
    note(K_OE, 0);
    addr_sw = 8'h00;
    wait_cycles(8);
    note(K_STA, t * 10 + u);
    turn(16384, 1);
    note(K_CNT, 16384);
    note(K_RISE, 4096);
    note(K_BAD, 0);
    turn(8192, -1);
    note(K_CNT, -8192);
    note(K_RISE, 2048);
    note(K_BAD, 0);
    low_pulse(60);
    low_pulse(25);
    low_pulse(40);
    note(K_BIT, 32'h8000_0019);
    feed_in_high = 1'b1;
    wait_cycles(6);
    feed_in_high = 1'b0;
    wait_cycles(6);
    note(K_RUN, 0);
    note(K_OE, 1);
    note(K_EN, 0);
    note(K_TXOE, 1);
    note(K_TX, 1);
    addr_sw = '{tens: t, units: u};
    reset_dut();
    supply_over = 1'b1;
    wait_cycles(HOLD - 5);
    supply_over = 1'b0;
    wait_cycles(8);
    note(K_LCK, 0);
    note(K_RUN, 1);
    supply_over = 1'b1;
    wait_cycles(HOLD + 10);
    supply_over = 1'b0;
    wait_cycles(8);
    note(K_LCK, 1);
    note(K_RUN, 0);
    report_and_stop();
  end
endmodule // quadrature_output_supervisor_test
